// ==== pcg_pkg.sv ====
package pcg_pkg;
    localparam logic [11:0] SRCTL0_OFS  = 12'h040;
    localparam logic [11:0] SRCTL1_OFS  = 12'h044;
    localparam logic [11:0] RUNGATE_OFS = 12'h108;
    localparam logic [11:0] SLPGATE_OFS = 12'h118;
    localparam logic [11:0] DSGATE_OFS  = 12'h128;
    localparam logic [11:0] RUNCFG_OFS  = 12'h060;
    localparam logic [11:0] CAP0_OFS    = 12'h010;
    localparam logic [11:0] CAP1_OFS    = 12'h014;
    localparam logic [11:0] PMODE_OFS   = 12'h300;
    localparam logic [11:0] IRQ_STAT_OFS = 12'h304;
    localparam logic [11:0] IRQ_EN_OFS   = 12'h308;
    localparam logic [11:0] IRQ_CLR_OFS  = 12'h30C;
    localparam logic [31:0] GATE_MASK   = 32'h5000007F;
    localparam logic [31:0] SR0_MASK    = 32'h00100008;
    localparam logic [31:0] SR1_MASK    = 32'h07070011;
    localparam logic [31:0] ZERO32      = 32'h00000000;
    localparam int          AUTO_GATE_BIT = 27;
    localparam int          NUM_UNITS   = 9;
    localparam int          NUM_IRQ     = 2;
    localparam int          IRQ_FAULT   = 0;
    localparam int          IRQ_MODE    = 1;
    typedef enum logic [1:0] {PCG_RUN, PCG_SLEEP, PCG_DEEP} pcg_mode_e;
endpackage

// ==== pcg_unit_gate.sv ====
`timescale 1ns/100ps
module pcg_unit_gate
    import pcg_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic unit_sel,
    output logic      unit_clk_en,
    output logic      unit_fault
);
    logic en_q;
    logic en_d;

    always_comb begin
        en_d = enable;
    end

    // Enable is registered so the downstream latch-free gate sees a glitch-free level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q <= 1'b0;
        end else begin
            en_q <= en_d;
        end
    end

    assign unit_clk_en = en_q;
    assign unit_fault  = unit_sel & ~en_q;
endmodule // pcg_unit_gate

// ==== pcg_top.sv ====
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
module pcg_top
    import pcg_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [11:0]          wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    output logic                      wb_err_o,
    input  wire logic                 unit_access,
    input  wire logic [NUM_UNITS-1:0] unit_sel,
    output logic                      unit_fault,
    output logic      [NUM_UNITS-1:0] unit_clk_en,
    output logic      [31:0]          periph_reset,
    output logic                      irq
);
    logic [31:0] run_gate_q, run_gate_d;
    logic [31:0] sleep_gate_q, sleep_gate_d;
    logic [31:0] deep_gate_q, deep_gate_d;
    logic [31:0] run_cfg_q, run_cfg_d;
    logic [31:0] cap_first_q, cap_first_d;
    logic [31:0] cap_second_q, cap_second_d;
    logic [31:0] sr0_q, sr0_d;
    logic [31:0] sr1_q, sr1_d;
    logic [1:0]  mode_q, mode_d;
    logic [NUM_IRQ-1:0] ist_q, ist_d;
    logic [NUM_IRQ-1:0] ien_q, ien_d;
    logic        ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [31:0] active_gate;
    logic [31:0] rd_mux;
    logic [NUM_UNITS-1:0] unit_en;
    logic [NUM_UNITS-1:0] unit_flt;
    logic        req;
    logic        wr;
    logic        mode_chg;
    pcg_mode_e   mode_now;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr  = req & wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wval  = wb_dat_i & wmask;
    assign mode_now = pcg_mode_e'(mode_q);

    // Gating register selection by power mode
    always_comb begin
        unique case (mode_now)
            PCG_RUN:   active_gate = run_gate_q;
            PCG_SLEEP: active_gate = run_cfg_q[AUTO_GATE_BIT] ?
                                     sleep_gate_q : run_gate_q;
            PCG_DEEP:  active_gate = run_cfg_q[AUTO_GATE_BIT] ?
                                     deep_gate_q : run_gate_q;
            default:   active_gate = run_gate_q;
        endcase
    end

    // Unit order: ports A..G, MAC, PHY
    assign unit_en = {active_gate[30], active_gate[28], active_gate[6:0]};

    genvar g;
    generate
        for (g = 0; g < NUM_UNITS; g++) begin : gen_gate
            pcg_unit_gate u_gate (
                .clk         (clk),
                .rst         (rst),
                .enable      (unit_en[g]),
                .unit_sel    (unit_sel[g]),
                .unit_clk_en (unit_clk_en[g]),
                .unit_fault  (unit_flt[g])
            );
        end
    endgenerate

    assign unit_fault = unit_access & (|unit_flt);
    assign mode_chg   = wr & (wb_adr_i == PMODE_OFS) & wb_sel_i[0];

    // Register writes
    always_comb begin
        run_gate_d   = run_gate_q;
        sleep_gate_d = sleep_gate_q;
        deep_gate_d  = deep_gate_q;
        run_cfg_d    = run_cfg_q;
        cap_first_d  = cap_first_q;
        cap_second_d = cap_second_q;
        sr0_d        = sr0_q;
        sr1_d        = sr1_q;
        mode_d       = mode_q;
        ien_d        = ien_q;
        ist_d        = ist_q;
        if (wr) begin
            unique case (wb_adr_i)
                RUNGATE_OFS: run_gate_d   = (run_gate_q & ~wmask) | (wval & GATE_MASK);
                SLPGATE_OFS: sleep_gate_d = (sleep_gate_q & ~wmask) | (wval & GATE_MASK);
                DSGATE_OFS:  deep_gate_d  = ((deep_gate_q & ~wmask) | wval) & GATE_MASK;
                RUNCFG_OFS:  run_cfg_d    = (run_cfg_q & ~wmask) | wval;
                CAP0_OFS:    cap_first_d  = (cap_first_q & ~wmask) | wval;
                CAP1_OFS:    cap_second_d = (cap_second_q & ~wmask) | wval;
                SRCTL0_OFS:  sr0_d = (sr0_q & ~(wmask & cap_first_q & SR0_MASK))
                                   | (wval & cap_first_q & SR0_MASK);
                SRCTL1_OFS:  sr1_d = (sr1_q & ~(wmask & cap_second_q & SR1_MASK))
                                   | (wval & cap_second_q & SR1_MASK);
                PMODE_OFS:   if (wb_sel_i[0] && wb_dat_i[1:0] != 2'h3) begin
                    mode_d = wb_dat_i[1:0];
                end
                IRQ_EN_OFS:  if (wb_sel_i[0]) begin
                    ien_d = wb_dat_i[NUM_IRQ-1:0];
                end
                IRQ_CLR_OFS: if (wb_sel_i[0]) begin
                    ist_d = ist_q & ~wb_dat_i[NUM_IRQ-1:0];
                end
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        if (unit_fault) begin
            ist_d[IRQ_FAULT] = 1'b1;
        end
        if (mode_chg) begin
            ist_d[IRQ_MODE] = 1'b1;
        end
    end

    always_comb begin
        unique case (wb_adr_i)
            RUNGATE_OFS:  rd_mux = run_gate_q;
            SLPGATE_OFS:  rd_mux = sleep_gate_q;
            DSGATE_OFS:   rd_mux = deep_gate_q;
            RUNCFG_OFS:   rd_mux = run_cfg_q;
            CAP0_OFS:     rd_mux = cap_first_q;
            CAP1_OFS:     rd_mux = cap_second_q;
            SRCTL0_OFS:   rd_mux = sr0_q;
            SRCTL1_OFS:   rd_mux = sr1_q;
            PMODE_OFS:    rd_mux = {30'h00000000, mode_q};
            IRQ_STAT_OFS: rd_mux = {30'h00000000, ist_q};
            IRQ_EN_OFS:   rd_mux = {30'h00000000, ien_q};
            default:      rd_mux = ZERO32;
        endcase
    end

    always_comb begin
        ack_d  = req;
        rdat_d = (req && !wb_we_i) ? rd_mux : rdat_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_gate_q   <= ZERO32;
            sleep_gate_q <= ZERO32;
            deep_gate_q  <= ZERO32;
            run_cfg_q    <= ZERO32;
            cap_first_q  <= SR0_MASK;
            cap_second_q <= SR1_MASK;
            sr0_q        <= ZERO32;
            sr1_q        <= ZERO32;
            mode_q       <= 2'h0;
            ist_q        <= '0;
            ien_q        <= '0;
            ack_q        <= 1'b0;
            rdat_q       <= ZERO32;
        end else begin
            run_gate_q   <= run_gate_d;
            sleep_gate_q <= sleep_gate_d;
            deep_gate_q  <= deep_gate_d;
            run_cfg_q    <= run_cfg_d;
            cap_first_q  <= cap_first_d;
            cap_second_q <= cap_second_d;
            sr0_q        <= sr0_d;
            sr1_q        <= sr1_d;
            mode_q       <= mode_d;
            ist_q        <= ist_d;
            ien_q        <= ien_d;
            ack_q        <= ack_d;
            rdat_q       <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = 1'b0;
    assign wb_dat_o = rdat_q;
    assign periph_reset = sr0_q | sr1_q;
    assign irq = |(ist_q & ien_q);

    sequence s_ds_write;
        wr && wb_adr_i == DSGATE_OFS && wb_sel_i == 4'hF;
    endsequence

    chk_gate_reset: assert property (@(posedge clk) $rose(!rst) |-> deep_gate_q == ZERO32)
        else $error("gating not clear after reset");
    chk_clk_gate: assert property (@(posedge clk) disable iff (rst)
        unit_en[0] |=> unit_clk_en[0])
        else $error("enabled unit not clocked");
    chk_clk_stop: assert property (@(posedge clk) disable iff (rst)
        !unit_en[8] |=> !unit_clk_en[8])
        else $error("disabled unit still clocked");
    chk_fault_resp: assert property (@(posedge clk) disable iff (rst)
        unit_access && (unit_sel & ~unit_clk_en) != '0 |-> unit_fault)
        else $error("no fault on unclocked access");
    chk_mode_run: assert property (@(posedge clk) disable iff (rst)
        mode_q == 2'h0 |-> active_gate == run_gate_q)
        else $error("run gating not applied");
    chk_auto_gate: assert property (@(posedge clk) disable iff (rst)
        !run_cfg_q[AUTO_GATE_BIT] |-> active_gate == run_gate_q)
        else $error("sleep gating without auto gate");
    chk_ds_layout: assert property (@(posedge clk) disable iff (rst)
        s_ds_write ##1 1 |-> deep_gate_q == ($past(wb_dat_i) & GATE_MASK))
        else $error("deep sleep gate layout wrong");
    chk_sr0_mask: assert property (@(posedge clk) disable iff (rst)
        (sr0_q & ~cap_first_q & ~$past(sr0_q)) == ZERO32)
        else $error("reset0 bit set against capability");
    chk_sr1_rsvd: assert property (@(posedge clk) disable iff (rst)
        (sr1_q & ~SR1_MASK) == ZERO32 && (sr0_q & ~SR0_MASK) == ZERO32)
        else $error("reserved reset bit set");
    chk_ack_pulse: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule // pcg_top

// ==== pcg_unit_model.sv ====
`timescale 1ns/100ps
// Stand-in for the gated units, raising one access at a time
module pcg_unit_model
    import pcg_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 req,
    input  wire logic [3:0]           idx,
    output logic                      unit_access,
    output logic      [NUM_UNITS-1:0] unit_sel
);
    // Idle select toggles so a stale target is never trusted
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unit_access <= 1'b0;
            unit_sel    <= '0;
        end else begin
            unit_access <= req;
            unit_sel    <= req ? (NUM_UNITS'(1) << idx) : ~unit_sel;
        end
    end
endmodule // pcg_unit_model

// ==== pcg_top_tb.sv ====
`timescale 1ns/100ps
module pcg_top_tb;
    import pcg_pkg::*;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0;
    logic [11:0]          adr = 12'h000;
    logic [3:0]           sel = 4'h0, idx = 4'h0;
    logic [31:0]          dat = 32'h00000000, dat_o, prst, r;
    logic                 ack, err, access, fault, irq;
    logic [NUM_UNITS-1:0] usel, clk_en;
    int                   fails = 0, comparisons = 0, cyc_n = 0;

    pcg_top u_pcg_top (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .wb_err_o(err), .unit_access(access), .unit_sel(usel), .unit_fault(fault),
        .unit_clk_en(clk_en), .periph_reset(prst), .irq(irq));
    pcg_unit_model u_pcg_unit_model (.clk(clk), .rst(rst), .req(req), .idx(idx),
        .unit_access(access), .unit_sel(usel));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic summarize();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Cut a hang short well past the expected few hundred cycles
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            fails++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        // Hold the request until ack is seen high at a rising edge
        do @(posedge clk); while (ack !== 1'b1);
        r = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    // Enables lag the register by one cycle
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic acc(input logic [3:0] i);
        @(posedge clk);
        req <= 1'b1; idx <= i;
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_reset();
        wb(0, SRCTL0_OFS, 0); chk("sr0", r, ZERO32);
        wb(0, SRCTL1_OFS, 0); chk("sr1", r, ZERO32);
        wb(0, DSGATE_OFS, 0); chk("dsgate", r, ZERO32);
        chk("clk_en", 32'(clk_en), ZERO32);
        chk("periph_reset", prst, ZERO32);
    endtask

    task automatic t_run_gate();
        wb(1, RUNGATE_OFS, 32'hFFFFFFFF); wb(0, RUNGATE_OFS, 0);
        chk("rungate", r, GATE_MASK);
        settle(); chk("clk_en", 32'(clk_en), 32'h000001FF);
        acc(4'h8); chk("fault", 32'(fault), 32'h0);
        req <= 1'b0;
        wb(1, RUNGATE_OFS, 0); settle();
        chk("clk_en", 32'(clk_en), ZERO32);
        acc(4'h0); chk("fault", 32'(fault), 32'h1);
        req <= 1'b0;
    endtask

    task automatic t_deep();
        wb(1, RUNGATE_OFS, 32'h10000001); wb(1, DSGATE_OFS, 32'hFFFFFFFF);
        wb(0, DSGATE_OFS, 0); chk("dsgate", r, GATE_MASK);
        wb(1, PMODE_OFS, 32'h2); settle();
        chk("clk_en", 32'(clk_en), 32'h00000081);
        wb(1, RUNCFG_OFS, 32'h08000000); settle();
        chk("clk_en", 32'(clk_en), 32'h000001FF);
        wb(1, DSGATE_OFS, 32'h40000040); settle();
        chk("clk_en", 32'(clk_en), 32'h00000140);
        wb(1, DSGATE_OFS, 32'h10000001); settle();
        chk("clk_en", 32'(clk_en), 32'h00000081);
        wb(1, SLPGATE_OFS, 32'h10000000); wb(1, PMODE_OFS, 32'h1); settle();
        chk("clk_en", 32'(clk_en), 32'h00000080);
        wb(1, PMODE_OFS, 32'h0); wb(1, RUNCFG_OFS, 0); settle();
        chk("clk_en", 32'(clk_en), 32'h00000081);
    endtask

    task automatic t_soft();
        wb(1, SRCTL0_OFS, 32'hFFFFFFFF); wb(0, SRCTL0_OFS, 0);
        chk("sr0", r, SR0_MASK);
        wb(1, SRCTL1_OFS, 32'hFFFFFFFF); wb(0, SRCTL1_OFS, 0);
        chk("sr1", r, SR1_MASK);
        settle(); chk("periph_reset", prst, SR0_MASK | SR1_MASK);
        wb(1, CAP0_OFS, 32'h00000008); wb(1, SRCTL0_OFS, 0); wb(0, SRCTL0_OFS, 0);
        chk("sr0", r, 32'h00100000);
        wb(1, CAP1_OFS, 32'h00000001); wb(1, SRCTL1_OFS, 0); wb(0, SRCTL1_OFS, 0);
        chk("sr1", r, 32'h07070010);
        wb(1, CAP0_OFS, SR0_MASK); wb(1, CAP1_OFS, SR1_MASK);
        wb(1, SRCTL0_OFS, 0); wb(1, SRCTL1_OFS, 0); settle();
        chk("periph_reset", prst, ZERO32);
    endtask

    task automatic t_irq();
        wb(1, IRQ_CLR_OFS, 32'h3); wb(1, IRQ_EN_OFS, 32'h1);
        acc(4'h1); chk("fault", 32'(fault), 32'h1);
        req <= 1'b0;
        settle(); chk("irq", 32'(irq), 32'h1);
        wb(1, IRQ_EN_OFS, 0); chk("irq", 32'(irq), 32'h0);
        wb(1, IRQ_EN_OFS, 32'h1); chk("irq", 32'(irq), 32'h1);
        wb(1, IRQ_CLR_OFS, 32'h1); chk("irq", 32'(irq), 32'h0);
        wb(0, IRQ_STAT_OFS, 0); chk("irq_stat", r, ZERO32);
        wb(1, IRQ_EN_OFS, 32'h2); wb(1, PMODE_OFS, 32'h0);
        chk("irq", 32'(irq), 32'h1);
        wb(1, IRQ_CLR_OFS, 32'h2); chk("irq", 32'(irq), 32'h0);
        wb(1, 12'h200, 32'hFFFFFFFF); wb(0, 12'h200, 0);
        chk("unmapped", r, ZERO32);
        chk("err", 32'(err), 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_run_gate();
        t_deep();
        t_soft();
        t_irq();
        summarize();
    end
endmodule // pcg_top_tb
